// ===== rtl/lsd_cfg.svh
// Register indices, field positions, reset values and timing counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef LSD_CFG_SVH
`define LSD_CFG_SVH
// Word indices; the AXI byte address is four times the index.
`define LSD_IDX_DUTY_SUPPLY 16'hff60
`define LSD_IDX_OVERRIDE 16'hff61
`define LSD_IDX_DMEM_BASE 16'hf000
`define LSD_IDX_DMEM_LAST 16'hf01f
`define LSD_ADDR_W 18
`define LSD_BIT_SUPPLY 0
`define LSD_BIT_SPARE 1
`define LSD_BIT_DUTY_LO 2
`define LSD_BIT_DUTY_HI 3
`define LSD_BIT_STATIC 0
`define LSD_BIT_LIT 1
`define LSD_BIT_DARK 2
`define LSD_CTRL_RST 4'h0
`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_SLVERR 2'h2
// Oscillator periods per common phase at 32.768 kHz.
`define LSD_PHASE_SHORT 10'h100
`define LSD_PHASE_LONG 10'h200
`endif

// ===== rtl/lsd_pkg.sv
// Types shared by the segment LCD controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package lsd_pkg;
	typedef enum logic [1:0] {LSD_DUTY_4, LSD_DUTY_3, LSD_DUTY_2} lsd_duty_e;
	typedef enum logic [1:0] {LSD_VSS, LSD_VC1, LSD_VC2, LSD_VC3} lsd_lvl_e;
	typedef logic [895:0] lsd_map_t;

	// Default allocation: segment s, common c shows word s, bit c.
	function automatic lsd_map_t lsd_ident_map();
		lsd_map_t m;
		m = '0;
		for (int s = 0; s < 32; s++) begin
			for (int c = 0; c < 4; c++) begin
				m[(s*4+c)*7 +: 7] = 7'((s*4)+c);
			end
		end
		return m;
	endfunction
endpackage

// ===== rtl/lsd_tim_if.sv
// Carries duty selection down and phase timing back up.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface lsd_tim_if;
	lsd_pkg::lsd_duty_e duty;
	logic [1:0] phase;
	logic pol;
	modport drv (input duty, output phase, output pol);
	modport sink (output duty, input phase, input pol);
endinterface

// ===== rtl/lsd_frame_gen.sv
// Common phase and frame polarity generator.
// Assumes osc_i is an asynchronous low-speed oscillator pin.
`timescale 1ns/10ps
`include "lsd_cfg.svh"
module lsd_frame_gen (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic osc_i,
	lsd_tim_if.drv tim
);
	logic osc_s1;
	logic osc_s2;
	logic osc_s3;
	logic osc_lvl;
	logic osc_tick;
	logic [9:0] cnt;
	logic [9:0] phase_len;
	logic [1:0] last_phase;

	always_ff @(posedge ref_clk_i) begin
		osc_s1 <= osc_i;
		osc_s2 <= osc_s1;
		osc_s3 <= osc_s2;
	end

	// A change counts only once the second and third stages agree.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			osc_lvl <= 1'b0;
		end else if (osc_s2 == osc_s3) begin
			osc_lvl <= osc_s3;
		end
	end

	assign osc_tick = (osc_s2 == osc_s3) && osc_s3 && !osc_lvl;

	always_comb begin
		case (tim.duty)
			lsd_pkg::LSD_DUTY_2: begin
				phase_len = `LSD_PHASE_LONG;
				last_phase = 2'h1;
			end
			lsd_pkg::LSD_DUTY_3: begin
				phase_len = `LSD_PHASE_SHORT;
				last_phase = 2'h2;
			end
			default: begin
				phase_len = `LSD_PHASE_SHORT;
				last_phase = 2'h3;
			end
		endcase
	end

	// Polarity flips every frame so the glass never sees a net DC bias.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			cnt <= 10'h0;
			tim.phase <= 2'h0;
			tim.pol <= 1'b0;
		end else if (tim.phase > last_phase) begin
			cnt <= 10'h0;
			tim.phase <= 2'h0;
		end else if (osc_tick) begin
			// A duty change can shorten the phase below the running count.
			if (cnt >= phase_len - 10'h1) begin
				cnt <= 10'h0;
				if (tim.phase == last_phase) begin
					tim.phase <= 2'h0;
					tim.pol <= !tim.pol;
				end else begin
					tim.phase <= tim.phase + 2'h1;
				end
			end else begin
				cnt <= cnt + 10'h1;
			end
		end
	end
endmodule

// ===== rtl/lsd_lcd_ctrl.sv
// Segment LCD controller: AXI4-Lite registers, display memory, drive codes.
// Assumes an external analog switch stage turns level codes into voltages.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "lsd_cfg.svh"
// Overview of operation
// - Four common and thirty-two segment outputs drive up to 128 segments.
// - Dynamic drive at 1/4, 1/3 or 1/2 duty using four levels.
// - Build option selects half bias, merging first and second levels.
// - Supply enable off forces every common and segment output to ground.
// - DC segment outputs ignore the supply enable entirely.
// - Force-all-lit lights every waveform segment; force-all-dark shows them unlit.
// - With both overrides set, force-all-lit wins.
// - Overrides and supply enable reset to zero.
// - Duty code: high bit gives 1/2, 01 gives 1/3, 00 gives 1/4.
// - Frame rate 32 Hz at 1/4 and 1/2, 42.7 Hz at 1/3.
// - Static drive: any set bit of a segment gives static lit waveform.
// - Static drive: all four bits clear gives the dynamic unlit waveform.
// - Decoder maps any display memory bit to any segment and common.
// - Allocated segment is lit when its bit is 1, unlit when 0.
// - Display memory of 32 four-bit words, readable, writable, not reset.
// - Segment pairs are built as waveform or DC outputs.
// - A DC segment drives the bit allocated to its first common position.
// - First control word: duty high, duty low, spare, supply enable.
// - Second control word: dark, lit, static; bit three reads zero.
module lsd_lcd_ctrl #(
	parameter bit HALF_BIAS = 1'b0,
	parameter logic [15:0] DC_PAIRS = 16'h0000,
	parameter lsd_pkg::lsd_map_t SEG_MAP = lsd_pkg::lsd_ident_map()
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic osc_i,
	input wire logic [`LSD_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [`LSD_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [7:0] common_outputs_o,
	output logic [63:0] segment_outputs_o,
	output logic [31:0] seg_dc_level_o
);
	lsd_tim_if tim ();

	logic [3:0] duty_supply_ctrl;
	logic [3:0] override_ctrl;
	logic [3:0] dmem [32];

	logic aw_have;
	logic w_have;
	logic [15:0] aw_idx;
	logic [3:0] w_data;
	logic w_en;
	logic do_write;
	logic [15:0] ar_idx;
	logic [31:0] next_rdata;
	logic next_rresp_err;

	logic lcd_supply_on;
	logic duty_sel_hi;
	logic duty_sel_lo;
	logic static_drive_sel;
	logic force_all_lit;
	logic force_all_dark;

	logic [3:0] dec [32];
	logic [7:0] next_com;
	logic [63:0] next_seg;
	logic [31:0] next_dc;
	logic [31:0] next_on;

	lsd_frame_gen u_frame_gen (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.osc_i(osc_i),
		.tim(tim)
	);

	assign lcd_supply_on = duty_supply_ctrl[`LSD_BIT_SUPPLY];
	assign duty_sel_hi = duty_supply_ctrl[`LSD_BIT_DUTY_HI];
	assign duty_sel_lo = duty_supply_ctrl[`LSD_BIT_DUTY_LO];
	assign static_drive_sel = override_ctrl[`LSD_BIT_STATIC];
	assign force_all_lit = override_ctrl[`LSD_BIT_LIT];
	assign force_all_dark = override_ctrl[`LSD_BIT_DARK];

	// The duty high bit alone picks half duty; the low bit is then ignored.
	always_comb begin
		if (duty_sel_hi) begin
			tim.duty = lsd_pkg::LSD_DUTY_2;
		end else if (duty_sel_lo) begin
			tim.duty = lsd_pkg::LSD_DUTY_3;
		end else begin
			tim.duty = lsd_pkg::LSD_DUTY_4;
		end
	end

	// Write address and data may arrive in either order; each is held
	// until both are present, then one response is issued.
	assign do_write = aw_have && w_have && !s_axi_bvalid_o;

	// Awready stays low from acceptance until the response is taken, so
	// only one write is ever in flight.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			s_axi_awready_o <= 1'b1;
			aw_have <= 1'b0;
			aw_idx <= 16'h0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			s_axi_awready_o <= 1'b0;
			aw_have <= 1'b1;
			aw_idx <= s_axi_awaddr_i[`LSD_ADDR_W-1:2];
		end else if (do_write) begin
			aw_have <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_awready_o <= 1'b1;
		end
	end

	// Only the low nibble and its byte lane reach the register file.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			s_axi_wready_o <= 1'b1;
			w_have <= 1'b0;
			w_data <= 4'h0;
			w_en <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			s_axi_wready_o <= 1'b0;
			w_have <= 1'b1;
			w_data <= s_axi_wdata_i[3:0];
			w_en <= s_axi_wstrb_i[0];
		end else if (do_write) begin
			w_have <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_wready_o <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `LSD_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			if (aw_idx == `LSD_IDX_DUTY_SUPPLY ||
				aw_idx == `LSD_IDX_OVERRIDE ||
				(aw_idx >= `LSD_IDX_DMEM_BASE &&
				aw_idx <= `LSD_IDX_DMEM_LAST)) begin
				s_axi_bresp_o <= `LSD_RESP_OKAY;
			end else begin
				s_axi_bresp_o <= `LSD_RESP_SLVERR;
			end
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			duty_supply_ctrl <= `LSD_CTRL_RST;
		end else if (do_write && w_en &&
			aw_idx == `LSD_IDX_DUTY_SUPPLY) begin
			duty_supply_ctrl <= w_data;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			override_ctrl <= `LSD_CTRL_RST;
		end else if (do_write && w_en &&
			aw_idx == `LSD_IDX_OVERRIDE) begin
			override_ctrl <= {1'b0, w_data[2:0]};
		end
	end

	// Display memory has no reset; software must clear it first.
	always_ff @(posedge ref_clk_i) begin
		if (do_write && w_en && aw_idx >= `LSD_IDX_DMEM_BASE &&
			aw_idx <= `LSD_IDX_DMEM_LAST) begin
			dmem[aw_idx[4:0]] <= w_data;
		end
	end

	assign ar_idx = s_axi_araddr_i[`LSD_ADDR_W-1:2];

	// Unmapped reads answer zero with an error response.
	always_comb begin
		next_rdata = 32'h0;
		next_rresp_err = 1'b0;
		if (ar_idx == `LSD_IDX_DUTY_SUPPLY) begin
			next_rdata[3:0] = duty_supply_ctrl;
		end else if (ar_idx == `LSD_IDX_OVERRIDE) begin
			next_rdata[3:0] = override_ctrl;
		end else if (ar_idx >= `LSD_IDX_DMEM_BASE &&
			ar_idx <= `LSD_IDX_DMEM_LAST) begin
			next_rdata[3:0] = dmem[ar_idx[4:0]];
		end else begin
			next_rresp_err = 1'b1;
		end
	end

	// Read handshake state; data and response are loaded alongside.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// Data and response load only on acceptance, so they stand unchanged
	// for as long as the master stalls rready.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `LSD_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rdata_o <= next_rdata;
			if (next_rresp_err) begin
				s_axi_rresp_o <= `LSD_RESP_SLVERR;
			end else begin
				s_axi_rresp_o <= `LSD_RESP_OKAY;
			end
		end
	end

	// Each segment/common slot picks one memory bit through the table.
	for (genvar s = 0; s < 32; s++) begin : g_seg
		for (genvar c = 0; c < 4; c++) begin : g_com
			localparam int P = (s*4+c)*7;
			assign dec[s][c] =
				dmem[SEG_MAP[P+2 +: 5]][SEG_MAP[P +: 2]];
		end
	end

	// Half bias ties the first two generated levels together.
	function automatic logic [1:0] lvl(input lsd_pkg::lsd_lvl_e l);
		if (HALF_BIAS && l == lsd_pkg::LSD_VC2) begin
			return 2'(lsd_pkg::LSD_VC1);
		end
		return 2'(l);
	endfunction

	// Per-segment lit decision, before any supply or DC handling.
	always_comb begin
		next_on = 32'h0;
		for (int s = 0; s < 32; s++) begin
			if (static_drive_sel) begin
				next_on[s] = |dec[s];
			end else begin
				next_on[s] = dec[s][tim.phase];
			end
			if (force_all_lit) begin
				next_on[s] = 1'b1;
			end else if (force_all_dark) begin
				next_on[s] = 1'b0;
			end
		end
	end

	// Static drive holds every common in its selected waveform.
	always_comb begin
		logic sel;
		sel = 1'b0;
		next_com = 8'h0;
		for (int c = 0; c < 4; c++) begin
			sel = static_drive_sel || (2'(c) == tim.phase);
			if (!lcd_supply_on) begin
				next_com[c*2 +: 2] = lvl(lsd_pkg::LSD_VSS);
			end else if (sel) begin
				next_com[c*2 +: 2] = tim.pol ?
					lvl(lsd_pkg::LSD_VSS) : lvl(lsd_pkg::LSD_VC3);
			end else begin
				next_com[c*2 +: 2] = tim.pol ?
					lvl(lsd_pkg::LSD_VC2) : lvl(lsd_pkg::LSD_VC1);
			end
		end
	end

	// DC pairs bypass the supply gate and the overrides alike.
	always_comb begin
		next_seg = 64'h0;
		next_dc = 32'h0;
		for (int s = 0; s < 32; s++) begin
			if (DC_PAIRS[s/2]) begin
				next_seg[s*2 +: 2] = lvl(lsd_pkg::LSD_VSS);
				next_dc[s] = dec[s][0];
			end else if (!lcd_supply_on) begin
				next_seg[s*2 +: 2] = lvl(lsd_pkg::LSD_VSS);
			end else if (next_on[s]) begin
				next_seg[s*2 +: 2] = tim.pol ?
					lvl(lsd_pkg::LSD_VC3) : lvl(lsd_pkg::LSD_VSS);
			end else begin
				next_seg[s*2 +: 2] = tim.pol ?
					lvl(lsd_pkg::LSD_VC1) : lvl(lsd_pkg::LSD_VC2);
			end
		end
	end

	// Registered so the analog switches never see decode glitches.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			common_outputs_o <= 8'h0;
		end else begin
			common_outputs_o <= next_com;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			segment_outputs_o <= 64'h0;
		end else begin
			segment_outputs_o <= next_seg;
		end
	end

	// A DC pin's level follows a memory write one cycle later.
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			seg_dc_level_o <= 32'h0;
		end else begin
			seg_dc_level_o <= next_dc;
		end
	end
endmodule

// ===== tb/lsd_panel.sv
// Glass panel model: a pixel is dark unless it sees the full drive swing.
// Assumes two-bit level codes on the common and segment electrodes.
`timescale 1ns/10ps
module lsd_panel (
	input wire logic [7:0] com_i,
	input wire logic [63:0] seg_i,
	output logic [31:0] on_o
);
	// Only a selected common against the opposite segment level spans
	// ground to level three, so supply off leaves every pixel dark.
	always_comb begin
		on_o = '0;
		for (int s = 0; s < 32; s++) begin
			for (int c = 0; c < 4; c++) begin
				if ({com_i[2*c+:2], seg_i[2*s+:2]} inside {4'hc, 4'h3}) begin
					on_o[s] = 1'b1;
				end
			end
		end
	end
endmodule

// ===== tb/lsd_lcd_ctrl_assertions.sv
// Bus handshake and drive-code checks on the controller's ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module lsd_lcd_ctrl_chk #(
	parameter logic [15:0] DC_PAIRS = 16'h0000
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] common_outputs_o,
	input wire logic [63:0] segment_outputs_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=>
			s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=>
			s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
	property p_ar_take;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
	endproperty
	a_ar_take: assert property (p_ar_take) else $error("read late");
	property p_aw_busy;
		s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("aw reopened");
	property p_b_after;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
			s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o;
	endproperty
	a_b_after: assert property (p_b_after) else $error("no bvalid");
	property p_b_done;
		s_axi_bvalid_o && s_axi_bready_i |=>
			!s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
	endproperty
	a_b_done: assert property (p_b_done) else $error("b not closed");
	property p_dc_quiet;
		DC_PAIRS[0] |-> segment_outputs_o[3:0] == 4'h0;
	endproperty
	a_dc_quiet: assert property (p_dc_quiet) else $error("dc pin waved");
	property p_pol;
		common_outputs_o[1:0] == 2'h3 |-> segment_outputs_o[5:4] inside {2'h0, 2'h2};
	endproperty
	a_pol: assert property (p_pol) else $error("segment polarity");
	c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
	c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
	c_sel: cover property (common_outputs_o[1:0] == 2'h3);
endmodule
bind lsd_lcd_ctrl lsd_lcd_ctrl_chk #(.DC_PAIRS(DC_PAIRS)) chk_i (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.common_outputs_o(common_outputs_o),
	.segment_outputs_o(segment_outputs_o));

// ===== tb/tb_top.sv
// Self-checking bench for the segment LCD controller.
// Assumes the design, its checker and the panel model are compiled first.
`timescale 1ns/10ps
`include "lsd_cfg.svh"
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic osc = 1'b0;
	logic [17:0] awaddr = '0;
	logic [17:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, arready, bvalid, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, dc, on, rd;
	logic [7:0] com;
	logic [63:0] seg;
	logic [3:0] mem [32];
	logic [3:0] ovr [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h1};
	logic [3:0] dty [3] = '{4'h3, 4'h5, 4'hd};
	int mdl [5] = '{0, 1, 2, 1, 3};
	int num_errors = 0, n_checks = 0, cyc = 0;
	// Pair 0 is built as DC so segments 0 and 1 never carry a waveform.
	lsd_lcd_ctrl #(.DC_PAIRS(16'h0001)) lsd_lcd_ctrl_i (
		.ref_clk_i(clk), .nrst_i(nrst), .osc_i(osc),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .common_outputs_o(com),
		.segment_outputs_o(seg), .seg_dc_level_o(dc));
	lsd_panel lsd_panel_i (.com_i(com), .seg_i(seg), .on_o(on));
	initial forever #25 clk = ~clk;
	// A fast oscillator keeps each common phase near a thousand cycles, two thousand at 1/2 duty.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 1) osc <= ~osc;
		if (cyc == 40000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic close_out();
		if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [3:0] d);
		@(posedge clk);
		awaddr <= {idx, 2'h0};
		wdata <= {28'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rd = {30'h0, bresp};
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [15:0] idx);
		@(posedge clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = (rresp == 2'h0) ? rdata : {rdata[29:0], rresp};
		rready <= 1'b0;
	endtask
	function automatic int sel_com(input logic [7:0] c);
		for (int i = 0; i < 4; i++) begin
			if (c[2*i+:2] inside {2'h3, 2'h0}) return i;
		end
		return 0;
	endfunction
	function automatic logic [31:0] exp_on(input int m, input int c);
		logic [31:0] e;
		e = '0;
		for (int s = 2; s < 32; s++) begin
			e[s] = m == 1 ? 1'b1 : m == 2 ? 1'b0 : m == 3 ? |mem[s] : mem[s][c];
		end
		return e;
	endfunction
	initial begin
		void'($urandom(98));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rdr(`LSD_IDX_DUTY_SUPPLY);
		chk(rd, 32'h0);
		rdr(`LSD_IDX_OVERRIDE);
		chk(rd, 32'h0);
		wr(`LSD_IDX_OVERRIDE, 4'hf);
		rdr(`LSD_IDX_OVERRIDE);
		chk(rd, 32'h7);
		wr(16'h1234, 4'h5);
		chk(rd, 32'h2);
		rdr(16'h1234);
		chk(rd, 32'h2);
		for (int i = 0; i < 32; i++) begin
			mem[i] = (i == 3) ? 4'h0 : (i == 4) ? 4'h8 : 4'($urandom);
			wr(`LSD_IDX_DMEM_BASE + 16'(i), mem[i]);
		end
		for (int i = 0; i < 32; i++) begin
			rdr(`LSD_IDX_DMEM_BASE + 16'(i));
			chk(rd, {28'h0, mem[i]});
		end
		repeat (4) @(posedge clk);
		chk({24'h0, com} | seg[31:0] | seg[63:32], 32'h0);
		chk(dc, {30'h0, mem[1][0], mem[0][0]});
		// The panel model has no settling time, so the long wait that real
		// glass needs after supply on is cut to the override loop's delay.
		wr(`LSD_IDX_DUTY_SUPPLY, 4'h1);
		for (int k = 0; k < 5; k++) begin
			wr(`LSD_IDX_OVERRIDE, ovr[k]);
			repeat ($urandom_range(4, 900)) @(posedge clk);
			chk(on & 32'hfffffffc, exp_on(mdl[k], sel_com(com)));
		end
		wr(`LSD_IDX_OVERRIDE, 4'h0);
		for (int d = 0; d < 3; d++) begin
			wr(`LSD_IDX_DUTY_SUPPLY, dty[d]);
			rdr(`LSD_IDX_DUTY_SUPPLY);
			chk(rd, {28'h0, dty[d]});
			for (int j = 0; j < 8; j++) begin
				repeat (700) @(posedge clk);
				chk(on & 32'hfffffffc, exp_on(0, sel_com(com)));
				chk(32'(sel_com(com) < 4 - d), 32'h1);
			end
		end
		wr(`LSD_IDX_DUTY_SUPPLY, 4'h0);
		mem[0] = ~mem[0];
		wr(`LSD_IDX_DMEM_BASE, mem[0]);
		repeat (4) @(posedge clk);
		chk({24'h0, com} | seg[31:0] | seg[63:32], 32'h0);
		chk(dc, {30'h0, mem[1][0], mem[0][0]});
		close_out();
	end
endmodule
